// ==== pkg/pcacap_pkg.sv ====
// Package with register map, field positions and reset values of the counter array
// Operation
// - Overflow flag sets when the shared counter rolls over from maximum to zero.
// - Interrupt requested while overflow flag and overflow interrupt enable are both set.
// - Overflow flag set by hardware or software write; only software clears it.
// - Counter runs only while run bit 6 of control register is one.
// - Module event flag set by match or capture, cleared only by software; bit n. This design has no match logic; only capture sets it.
// - Module captures when its falling, rising or both capture enables are set.
// - Capture input pin sampled for a transition matching the enabled edges.
// - Valid transition copies counter bytes to capture registers and sets event flag.
// - Module interrupt only when its event flag and interrupt enable are set.
// - Watchdog function belongs to module 4 only, enabled by mode bit.
// - Unimplemented control bit 5 reads as zero.
package pcacap_pkg;
  localparam int unsigned PCACAP_NMOD = 5;
  localparam int unsigned PCACAP_WDT_MOD = 4;
  // Byte addresses on the register bus
  localparam logic [7:0] PCACAP_A_CTRL   = 8'hD8;
  localparam logic [7:0] PCACAP_A_MODE   = 8'hDC;
  localparam logic [7:0] PCACAP_A_CNTL   = 8'hE8;
  localparam logic [7:0] PCACAP_A_CNTH   = 8'hF8;
  // Five-word banks, spaced apart so no bank reaches into a neighbour
  localparam logic [7:0] PCACAP_A_MMODE0 = 8'h60;
  localparam logic [7:0] PCACAP_A_CAPL0  = 8'h80;
  localparam logic [7:0] PCACAP_A_CAPH0  = 8'hA0;
  localparam logic [7:0] PCACAP_A_ISTAT  = 8'hC8;
  localparam logic [7:0] PCACAP_A_IMASK  = 8'hCC;
  // Control register fields
  localparam int unsigned PCACAP_B_OVF = 7;
  localparam int unsigned PCACAP_B_RUN = 6;
  localparam int unsigned PCACAP_B_RSV = 5;
  // Counter mode register fields
  localparam int unsigned PCACAP_B_WDTE   = 6;
  localparam int unsigned PCACAP_B_OVF_IE = 0;
  // Module mode register fields
  localparam int unsigned PCACAP_B_RISE = 5;
  localparam int unsigned PCACAP_B_FALL = 4;
  localparam int unsigned PCACAP_B_MIE  = 0;
  localparam logic [7:0] PCACAP_MODE_MASK  = 8'hC7;
  localparam logic [7:0] PCACAP_MMODE_MASK = 8'h7F;
  localparam logic [7:0] PCACAP_RST8 = 8'h00;
  localparam logic [15:0] PCACAP_CNT_MAX = 16'hFFFF;
  localparam logic [1:0] PCACAP_RESP_OK  = 2'h0;
  localparam logic [1:0] PCACAP_RESP_ERR = 2'h2;
endpackage

// ==== logic/pcacap_edge.sv ====
// Per-module capture edge detector on the capture input pin
module pcacap_edge
  import pcacap_pkg::*;
(
  input  wire logic aclk,
  input  wire logic aresetn,
  input  wire logic ce,
  input  wire logic pin,
  input  wire logic rise_en,
  input  wire logic fall_en,
  output logic      hit
);
  logic pin_q;

  // Previous pin level, inputs are synchronous
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pin_q <= 1'b0;
    end else if (ce) begin
      pin_q <= pin;
    end
  end

  // Edge match against the enabled selection
  assign hit = ce & ((rise_en & pin & ~pin_q) | (fall_en & ~pin & pin_q));

  property p_edge;
    @(posedge aclk) disable iff (!aresetn)
      hit |-> (rise_en && pin && !$past(pin)) || (fall_en && !pin && $past(pin));
  endproperty
  a_edge: assert property (p_edge) else $error("edge hit without enabled transition");
endmodule

// ==== logic/pcacap_top.sv ====
// Counter array control, flags and capture modules behind an AXI4-Lite slave
module pcacap_top
  import pcacap_pkg::*;
#(
  parameter int unsigned NMOD = PCACAP_NMOD
) (
  input  wire logic                  aclk,
  input  wire logic                  aresetn,
  input  wire logic                  ce,
  input  wire logic [NMOD-1:0]       capture_input_pin,
  output logic                       counter_array_irq,
  output logic                       watchdog_enable,
  input  wire logic [7:0]            s_axi_awaddr,
  input  wire logic                  s_axi_awvalid,
  output logic                       s_axi_awready,
  input  wire logic [31:0]           s_axi_wdata,
  input  wire logic [3:0]            s_axi_wstrb,
  input  wire logic                  s_axi_wvalid,
  output logic                       s_axi_wready,
  output logic [1:0]                 s_axi_bresp,
  output logic                       s_axi_bvalid,
  input  wire logic                  s_axi_bready,
  input  wire logic [7:0]            s_axi_araddr,
  input  wire logic                  s_axi_arvalid,
  output logic                       s_axi_arready,
  output logic [31:0]                s_axi_rdata,
  output logic [1:0]                 s_axi_rresp,
  output logic                       s_axi_rvalid,
  input  wire logic                  s_axi_rready
);
  initial begin
    if (NMOD != PCACAP_NMOD) begin
      $error("module count must equal five, watchdog sits on module 4");
    end
  end

  logic [7:0]       ctrl_q;
  logic [7:0]       mode_q;
  logic [7:0]       mmode_q [NMOD];
  logic [7:0]       capl_q  [NMOD];
  logic [7:0]       caph_q  [NMOD];
  logic [15:0]      cnt_q;
  logic [NMOD+1:0]  ist_q;
  logic [NMOD+1:0]  imask_q;
  logic [NMOD-1:0]  hit;
  logic             ovf_ev;
  logic [7:0]       aw_q;
  logic [31:0]      wd_q;
  logic [3:0]       ws_q;
  logic             awh_q;
  logic             wh_q;
  logic             wr_go;
  logic             rd_go;
  logic [31:0]      rd_d;
  logic             rd_ok;
  logic             wr_ok;
  logic [7:0]       wb;

  // Address decode helpers for per-module register banks
  function automatic logic is_bank(input logic [7:0] a, input logic [7:0] base);
    return (a >= base) && (a < base + 8'(4 * NMOD)) && (a[1:0] == 2'h0);
  endfunction
  function automatic int unsigned bank_idx(input logic [7:0] a, input logic [7:0] base);
    return int'((a - base) >> 2);
  endfunction

  // Write channels may arrive in either order; hold each until both present
  // Readies drop while frozen so no handshake is lost during a stall
  assign s_axi_awready = ~awh_q & ~s_axi_bvalid & ce;
  assign s_axi_wready  = ~wh_q & ~s_axi_bvalid & ce;
  assign wr_go = (awh_q | s_axi_awvalid) & (wh_q | s_axi_wvalid) & ~s_axi_bvalid & ce;
  wire [7:0]  wa = awh_q ? aw_q : s_axi_awaddr;
  wire [31:0] wdv = wh_q ? wd_q : s_axi_wdata;
  wire [3:0]  wsv = wh_q ? ws_q : s_axi_wstrb;
  assign wb = wdv[7:0];
  wire wlane = wsv[0];

  // Latch write address and data halves
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awh_q <= 1'b0;
      wh_q  <= 1'b0;
      aw_q  <= PCACAP_RST8;
      wd_q  <= 32'h0000_0000;
      ws_q  <= 4'h0;
    end else if (ce) begin
      if (wr_go) begin
        awh_q <= 1'b0;
        wh_q  <= 1'b0;
      end else begin
        if (s_axi_awvalid && s_axi_awready) begin
          awh_q <= 1'b1;
          aw_q  <= s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
          wh_q <= 1'b1;
          wd_q <= s_axi_wdata;
          ws_q <= s_axi_wstrb;
        end
      end
    end
  end

  // Write decode; unmapped addresses answer SLVERR
  always_comb begin
    wr_ok = (wa == PCACAP_A_CTRL) || (wa == PCACAP_A_MODE) || (wa == PCACAP_A_CNTL) ||
            (wa == PCACAP_A_CNTH) || (wa == PCACAP_A_IMASK) || (wa == PCACAP_A_ISTAT) ||
            is_bank(wa, PCACAP_A_MMODE0) || is_bank(wa, PCACAP_A_CAPL0) ||
            is_bank(wa, PCACAP_A_CAPH0);
  end

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= PCACAP_RESP_OK;
    end else if (ce) begin
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_ok ? PCACAP_RESP_OK : PCACAP_RESP_ERR;
      end else if (s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  wire wr_ctrl = wr_go & wlane & (wa == PCACAP_A_CTRL);
  wire wr_cntl = wr_go & wlane & (wa == PCACAP_A_CNTL);
  wire wr_cnth = wr_go & wlane & (wa == PCACAP_A_CNTH);
  wire run = ctrl_q[PCACAP_B_RUN];
  assign ovf_ev = ce & run & (cnt_q == PCACAP_CNT_MAX);

  // Shared 16-bit counter, software may preload either byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt_q <= 16'h0000;
    end else if (ce) begin
      if (wr_cntl) begin
        cnt_q[7:0] <= wb;
      end else if (wr_cnth) begin
        cnt_q[15:8] <= wb;
      end else if (run) begin
        cnt_q <= cnt_q + 16'h0001;
      end
    end
  end

  // Control register: hardware set wins over a software clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ctrl_q <= PCACAP_RST8;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_q[PCACAP_B_RUN] <= wb[PCACAP_B_RUN];
        ctrl_q[PCACAP_B_OVF] <= wb[PCACAP_B_OVF] | ovf_ev;
        ctrl_q[NMOD-1:0] <= (ctrl_q[NMOD-1:0] & wb[NMOD-1:0]) | hit;
      end else begin
        ctrl_q[PCACAP_B_OVF] <= ctrl_q[PCACAP_B_OVF] | ovf_ev;
        ctrl_q[NMOD-1:0] <= ctrl_q[NMOD-1:0] | hit;
      end
    end
  end

  // Counter mode register; reserved bits held at zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_q <= PCACAP_RST8;
    end else if (ce && wr_go && wlane && wa == PCACAP_A_MODE) begin
      mode_q <= wb & PCACAP_MODE_MASK;
    end
  end
  // Watchdog function only on module 4
  assign watchdog_enable = mode_q[PCACAP_B_WDTE] &
                           (mmode_q[PCACAP_WDT_MOD] != PCACAP_RST8);

  // Per-module mode, capture registers and edge detection
  for (genvar m = 0; m < NMOD; m++) begin : g_mod
    wire wr_mm = wr_go & wlane & is_bank(wa, PCACAP_A_MMODE0) &&
                 bank_idx(wa, PCACAP_A_MMODE0) == m;
    wire wr_cl = wr_go & wlane & is_bank(wa, PCACAP_A_CAPL0) &&
                 bank_idx(wa, PCACAP_A_CAPL0) == m;
    wire wr_ch = wr_go & wlane & is_bank(wa, PCACAP_A_CAPH0) &&
                 bank_idx(wa, PCACAP_A_CAPH0) == m;
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        mmode_q[m] <= PCACAP_RST8;
      end else if (ce && wr_mm) begin
        mmode_q[m] <= wb & PCACAP_MMODE_MASK;
      end
    end
    pcacap_edge u_edge (
      .aclk    (aclk),
      .aresetn (aresetn),
      .ce      (ce),
      .pin     (capture_input_pin[m]),
      .rise_en (mmode_q[m][PCACAP_B_RISE]),
      .fall_en (mmode_q[m][PCACAP_B_FALL]),
      .hit     (hit[m])
    );
    // Capture beats a same-cycle software write
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        capl_q[m] <= PCACAP_RST8;
        caph_q[m] <= PCACAP_RST8;
      end else if (ce) begin
        if (hit[m]) begin
          capl_q[m] <= cnt_q[7:0];
          caph_q[m] <= cnt_q[15:8];
        end else begin
          if (wr_cl) capl_q[m] <= wb;
          if (wr_ch) caph_q[m] <= wb;
        end
      end
    end
  end

  // Interrupt sources: overflow, module flags gated by enables
  logic [NMOD:0] src;
  always_comb begin
    src[NMOD] = ctrl_q[PCACAP_B_OVF] & mode_q[PCACAP_B_OVF_IE];
    for (int i = 0; i < NMOD; i++) begin
      src[i] = ctrl_q[i] & mmode_q[i][PCACAP_B_MIE];
    end
  end
  assign counter_array_irq = |src;

  // Sticky event status, cleared by a read, events win over the clear
  wire rd_ist = rd_go & (s_axi_araddr == PCACAP_A_ISTAT);
  wire [NMOD+1:0] ev = {ovf_ev, 1'b0, hit};
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ist_q   <= '0;
      imask_q <= '0;
    end else if (ce) begin
      ist_q <= (rd_ist ? '0 : ist_q) | ev;
      if (wr_go && wlane && wa == PCACAP_A_IMASK) imask_q <= wb[NMOD+1:0];
    end
  end
  wire status_irq = |(ist_q & imask_q);

  // Read path with registered data
  assign s_axi_arready = ~s_axi_rvalid & ce;
  assign rd_go = s_axi_arvalid & s_axi_arready & ce;
  always_comb begin
    rd_d  = 32'h0000_0000;
    rd_ok = 1'b1;
    if (s_axi_araddr == PCACAP_A_CTRL) rd_d[7:0] = ctrl_q;
    else if (s_axi_araddr == PCACAP_A_MODE) rd_d[7:0] = mode_q;
    else if (s_axi_araddr == PCACAP_A_CNTL) rd_d[7:0] = cnt_q[7:0];
    else if (s_axi_araddr == PCACAP_A_CNTH) rd_d[7:0] = cnt_q[15:8];
    else if (s_axi_araddr == PCACAP_A_ISTAT) rd_d[NMOD+1:0] = ist_q;
    else if (s_axi_araddr == PCACAP_A_IMASK) rd_d[NMOD+1:0] = imask_q;
    else if (is_bank(s_axi_araddr, PCACAP_A_MMODE0))
      rd_d[7:0] = mmode_q[bank_idx(s_axi_araddr, PCACAP_A_MMODE0)];
    else if (is_bank(s_axi_araddr, PCACAP_A_CAPL0))
      rd_d[7:0] = capl_q[bank_idx(s_axi_araddr, PCACAP_A_CAPL0)];
    else if (is_bank(s_axi_araddr, PCACAP_A_CAPH0))
      rd_d[7:0] = caph_q[bank_idx(s_axi_araddr, PCACAP_A_CAPH0)];
    else rd_ok = 1'b0;
  end
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= PCACAP_RESP_OK;
    end else if (ce) begin
      if (rd_go) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata  <= rd_d;
        s_axi_rresp  <= rd_ok ? PCACAP_RESP_OK : PCACAP_RESP_ERR;
      end else if (s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Checks; flag and capture properties watch modules 0 and 1 as representatives
  property p_ovf_set;
    @(posedge aclk) disable iff (!aresetn) ovf_ev |=> ctrl_q[PCACAP_B_OVF];
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("overflow flag not set");

  property p_ovf_irq;
    @(posedge aclk) disable iff (!aresetn)
      (ctrl_q[PCACAP_B_OVF] && mode_q[PCACAP_B_OVF_IE]) |-> counter_array_irq;
  endproperty
  a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq missing");

  property p_ovf_hold;
    @(posedge aclk) disable iff (!aresetn)
      ($past(ctrl_q[PCACAP_B_OVF]) && !$past(wr_ctrl)) |-> ctrl_q[PCACAP_B_OVF];
  endproperty
  a_ovf_hold: assert property (p_ovf_hold) else $error("overflow flag lost");

  property p_stop;
    @(posedge aclk) disable iff (!aresetn)
      (!run && !wr_cntl && !wr_cnth) |=> $stable(cnt_q);
  endproperty
  a_stop: assert property (p_stop) else $error("counter ran while stopped");

  property p_run;
    @(posedge aclk) disable iff (!aresetn)
      (run && ce && !wr_cntl && !wr_cnth) |=> cnt_q == $past(cnt_q) + 16'h0001;
  endproperty
  a_run: assert property (p_run) else $error("counter did not count");

  property p_flag;
    @(posedge aclk) disable iff (!aresetn) hit[0] |=> ctrl_q[0];
  endproperty
  a_flag: assert property (p_flag) else $error("module flag not set");

  property p_cap;
    @(posedge aclk) disable iff (!aresetn)
      hit[1] |=> {caph_q[1], capl_q[1]} == $past(cnt_q);
  endproperty
  a_cap: assert property (p_cap) else $error("capture value wrong");

  property p_mirq;
    @(posedge aclk) disable iff (!aresetn)
      counter_array_irq |-> (ctrl_q[PCACAP_B_OVF] && mode_q[PCACAP_B_OVF_IE]) ||
        (|(ctrl_q[NMOD-1:0] & {mmode_q[4][PCACAP_B_MIE], mmode_q[3][PCACAP_B_MIE],
        mmode_q[2][PCACAP_B_MIE], mmode_q[1][PCACAP_B_MIE], mmode_q[0][PCACAP_B_MIE]}));
  endproperty
  a_mirq: assert property (p_mirq) else $error("irq without enabled flag");

  property p_bit5;
    @(posedge aclk) disable iff (!aresetn)
      (rd_go && s_axi_araddr == PCACAP_A_CTRL) |=> !s_axi_rdata[PCACAP_B_RSV];
  endproperty
  a_bit5: assert property (p_bit5) else $error("reserved control bit read as one");

  property p_wdt;
    @(posedge aclk) disable iff (!aresetn) watchdog_enable |-> mode_q[PCACAP_B_WDTE];
  endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog without enable");

  property p_freeze;
    @(posedge aclk) disable iff (!aresetn)
      !ce |=> $stable(cnt_q) && $stable(ctrl_q);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved while clock enable low");
  c_cap: cover property (@(posedge aclk) disable iff (!aresetn) hit[0] ##1 ctrl_q[0]);
  c_ovf: cover property (@(posedge aclk) disable iff (!aresetn) ovf_ev);
  c_irq: cover property (@(posedge aclk) disable iff (!aresetn) status_irq && counter_array_irq);
endmodule

// ==== dv/cac_pin_model.sv ====
// Far-side model of the capture input pins, answering promptly or slowly
module cac_pin_model (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       slow,
  input  wire logic [4:0] want,
  output logic      [4:0] pin
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [4:0] dly_q [3];
  // Push-pull source, so the pin level is always defined
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dly_q <= '{default: 5'h00};
      pin   <= 5'h00;
    end else begin
      dly_q <= '{want, dly_q[0], dly_q[1]};
      pin   <= slow ? dly_q[2] : want;
    end
  end
endmodule

// ==== dv/test_counter_array_capture.sv ====
// Self-checking bench for counter array control, flags and capture
module test_counter_array_capture
  import pcacap_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic        aclk, aresetn, ce, slow;
  logic [4:0]  want, capture_input_pin;
  logic        counter_array_irq, watchdog_enable;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, mm;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rs;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [15:0] v;
  int          n_fail, checked, cyc, k, n;

  pcacap_top #(.NMOD(5)) DUT (
    .aclk, .aresetn, .ce, .capture_input_pin, .counter_array_irq, .watchdog_enable,
    .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready
  );
  cac_pin_model PIN (.aclk, .aresetn, .slow, .want, .pin(capture_input_pin));

  // Free-running 20 MHz clock
  initial begin
    aclk = 1'b0;
    forever #25 aclk = ~aclk;
  end

  task automatic test_done();
    $display("checked=%0d n_fail=%0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      test_done();
    end
  end

  task automatic chk(input logic [33:0] got, input logic [33:0] exp);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Ready is sampled at the falling edge, the level it holds at the next rising edge
  task automatic axw(input logic [7:0] a, input logic [7:0] d, output logic [1:0] r);
    logic aw_ok, w_ok, b_ok;
    b_ok = 1'b0;
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= {24'h000000, d};
    s_axi_wstrb   <= 4'h1;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    while (!b_ok) begin
      @(negedge aclk);
      aw_ok = s_axi_awvalid && s_axi_awready;
      w_ok = s_axi_wvalid && s_axi_wready;
      b_ok = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge aclk);
      if (aw_ok) s_axi_awvalid <= 1'b0;
      if (w_ok) s_axi_wvalid <= 1'b0;
      if (b_ok) s_axi_bready <= 1'b0;
    end
  endtask

  task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_ok, r_ok;
    r_ok = 1'b0;
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    while (!r_ok) begin
      @(negedge aclk);
      ar_ok = s_axi_arvalid && s_axi_arready;
      r_ok = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge aclk);
      if (ar_ok) s_axi_arvalid <= 1'b0;
      if (r_ok) s_axi_rready <= 1'b0;
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    axw(a, d, rs);
    chk(34'(rs), 34'(PCACAP_RESP_OK));
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [7:0] e);
    axr(a, rd, rs);
    chk({rs, rd}, {PCACAP_RESP_OK, 24'h000000, e});
  endtask

  task automatic irqchk(input logic e);
    @(negedge aclk);
    chk(34'(counter_array_irq), 34'(e));
  endtask

  // Main sequence
  initial begin
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
    {want, slow, n_fail, checked, cyc} = '0;
    ce = 1'b1;
    aresetn = 1'b0;
    void'($urandom(2277));
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    rdchk(PCACAP_A_CTRL, 8'h00);
    rdchk(PCACAP_A_MODE, 8'h00);
    axr(8'h04, rd, rs);
    chk(34'(rs), 34'(PCACAP_RESP_ERR));
    wr(PCACAP_A_IMASK, 8'h55);
    rdchk(PCACAP_A_IMASK, 8'h55);
    // Stopped counter holds a loaded value
    v = 16'($urandom);
    wr(PCACAP_A_CNTL, v[7:0]);
    wr(PCACAP_A_CNTH, v[15:8]);
    repeat (8) @(posedge aclk);
    rdchk(PCACAP_A_CNTL, v[7:0]);
    rdchk(PCACAP_A_CNTH, v[15:8]);
    // Roll over from FFFF; reserved bit 5 always written as zero
    wr(PCACAP_A_CNTH, 8'hFF);
    wr(PCACAP_A_CNTL, 8'hF0);
    wr(PCACAP_A_CTRL, 8'h40);
    n = 0;
    do begin
      axr(PCACAP_A_CTRL, rd, rs);
      n++;
    end while (rd[7] !== 1'b1 && n < 40);
    chk(34'(rd[7:6]), 34'h3);
    wr(PCACAP_A_CTRL, 8'h80);
    irqchk(1'b0);
    wr(PCACAP_A_MODE, 8'h01);
    irqchk(1'b1);
    rdchk(PCACAP_A_CTRL, 8'h80);
    rdchk(PCACAP_A_ISTAT, 8'h40);
    rdchk(PCACAP_A_ISTAT, 8'h00);
    wr(PCACAP_A_CTRL, 8'h00);
    irqchk(1'b0);
    wr(PCACAP_A_CTRL, 8'h80);
    rdchk(PCACAP_A_CTRL, 8'h80);
    wr(PCACAP_A_CTRL, 8'h00);
    wr(PCACAP_A_MODE, 8'h00);
    // Each module: rising, falling or both edges, prompt or slow pin
    for (int m = 0; m < 5; m++) begin
      k = m % 3;
      v = 16'($urandom);
      slow <= (m % 2 == 1);
      mm = {2'b00, k != 1, k != 0, 4'h1};
      wr(PCACAP_A_CNTL, v[7:0]);
      wr(PCACAP_A_CNTH, v[15:8]);
      wr(PCACAP_A_MMODE0 + 8'(4 * m), mm);
      want[m] <= 1'b1;
      repeat (8) @(posedge aclk);
      rdchk(PCACAP_A_CTRL, 8'(k != 1) << m);
      want[m] <= 1'b0;
      repeat (8) @(posedge aclk);
      rdchk(PCACAP_A_CTRL, 8'h01 << m);
      rdchk(PCACAP_A_CAPL0 + 8'(4 * m), v[7:0]);
      rdchk(PCACAP_A_CAPH0 + 8'(4 * m), v[15:8]);
      irqchk(1'b1);
      wr(PCACAP_A_MMODE0 + 8'(4 * m), mm & 8'hFE);
      irqchk(1'b0);
      wr(PCACAP_A_CTRL, 8'h1F);
      rdchk(PCACAP_A_CTRL, 8'h01 << m);
      wr(PCACAP_A_CTRL, 8'h00);
      rdchk(PCACAP_A_CTRL, 8'h00);
      rdchk(PCACAP_A_ISTAT, 8'h01 << m);
      rdchk(PCACAP_A_ISTAT, 8'h00);
      wr(PCACAP_A_MMODE0 + 8'(4 * m), 8'h00);
    end
    // Clock enable low for a random stretch must freeze the running counter
    wr(PCACAP_A_CNTL, 8'h00);
    wr(PCACAP_A_CNTH, 8'h00);
    wr(PCACAP_A_CTRL, 8'h40);
    ce <= 1'b0;
    repeat (2 + $urandom % 20) @(posedge aclk);
    ce <= 1'b1;
    wr(PCACAP_A_CTRL, 8'h00);
    rdchk(PCACAP_A_CNTL, 8'h03);
    rdchk(PCACAP_A_CNTH, 8'h00);
    // Watchdog follows module 4 only
    wr(PCACAP_A_MODE, 8'h40);
    wr(PCACAP_A_MMODE0 + 8'h10, 8'h01);
    @(negedge aclk);
    chk(34'(watchdog_enable), 34'h1);
    wr(PCACAP_A_MMODE0 + 8'h10, 8'h00);
    wr(PCACAP_A_MMODE0 + 8'h0C, 8'h01);
    @(negedge aclk);
    chk(34'(watchdog_enable), 34'h0);
    test_done();
  end
endmodule
